// >>> pkg/acrb_pkg.sv
// constants, types and register map of the adc configuration register bank
// Summary of operation
// - reserved bits of every configuration register read as zero and ignore writes.
// - while force_all_analog is set all eight channels act as analog inputs whatever else is set.
// - writing one to offset_calibrate starts a calibration and the bit clears itself when it ends.
// - writing one to the write-only defaults trigger restores all defaults except the interrupt status and mask, and in the same cycle sets brownout_flag.
// - while fixed_pattern_output is set every data read returns the code 0xA5A.
// - append_tag_select code 01 appends the 4-bit channel id to each result and code 00 does not.
// - spi_mode_select picks clock polarity and phase, and the host clocks the link in that mode.
// - averaging_ratio code n averages two to the n samples, code 0 meaning no averaging.
// - oscillator_select zero picks the high-speed and one the low-power oscillator.
// - a four-bit read-write timing_divider feeds the timing control.
// - each channel_function_map bit makes its pin analog at zero and general-purpose at one.
// - each digital_direction_map bit makes its pin an input at zero and an output at one.
// - brownout_flag is set on brown-out or power cycling and cleared by writing one to it.
package acrb_pkg;
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_SYSTEM_STATUS = 6'h00;
    localparam logic [5:0] IDX_GENERAL_CONFIG = 6'h01;
    localparam logic [5:0] IDX_OUTPUT_DATA_CONFIG = 6'h02;
    localparam logic [5:0] IDX_AVERAGING_CONFIG = 6'h03;
    localparam logic [5:0] IDX_OPERATING_MODE_CONFIG = 6'h04;
    localparam logic [5:0] IDX_CHANNEL_FUNCTION_CONFIG = 6'h05;
    localparam logic [5:0] IDX_DIGITAL_DIRECTION_CONFIG = 6'h07;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    // field positions
    localparam int BIT_FORCE_ALL_ANALOG = 2;
    localparam int BIT_OFFSET_CALIBRATE = 1;
    localparam int BIT_DEFAULTS_TRIGGER = 0;
    localparam int BIT_FIXED_PATTERN = 7;
    localparam int BIT_OSC_SELECT = 4;
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_STATUS_ONE = 7;
    // writable field masks, everything else reserved except the write-only defaults trigger
    localparam logic [7:0] MASK_GENERAL_CONFIG = 8'h06;
    localparam logic [7:0] MASK_OUTPUT_DATA_CONFIG = 8'hB3;
    localparam logic [7:0] MASK_AVERAGING_CONFIG = 8'h07;
    localparam logic [7:0] MASK_OPERATING_MODE_CONFIG = 8'h1F;
    localparam logic [2:0] MASK_IRQ = 3'h7;
    // reset values
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_SYSTEM_STATUS = 8'h81;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // data path constants
    localparam logic [11:0] FIXED_PATTERN_CODE = 12'hA5A;
    localparam logic [1:0] TAG_APPEND_CODE = 2'h1;
    // calibration time and its cycle count at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CAL_TIME_NS = 512;
    localparam int CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // interrupt event bits
    localparam int EV_CAL_DONE = 0;
    localparam int EV_DEFAULTS_DONE = 1;
    localparam int EV_BROWNOUT = 2;
    // calibration sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN = 2'b10
    } acrb_cal_state_t;
    // configuration handed to the converter core
    typedef struct packed {
        logic osc_low_power;
        logic [3:0] timing_divider;
        logic [2:0] averaging_ratio;
        logic [7:0] average_count;
        logic cpol;
        logic cpha;
        logic tag_enable;
    } acrb_cfg_t;
    // channel pin steering
    typedef struct packed {
        logic [7:0] is_gpio;
        logic [7:0] is_output;
    } acrb_pin_t;
endpackage

// >>> core/acrb_regs.sv
// apb register bank for adc configuration, channel steering and result formatting
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module acrb_regs
    import acrb_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
)
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // brown-out detector, asynchronous level
    input wire logic brownout_det,
    // converter core, same clock
    input wire logic result_valid,
    input wire logic [11:0] result_code,
    input wire logic [3:0] result_channel,
    output logic [15:0] data_word,
    output logic data_word_valid,
    output logic cal_active,
    output acrb_cfg_t cfg,
    output acrb_pin_t pins,
    // interrupt
    output logic irq
);

    // the pin steering structs are sized for eight channels
    // refused at elaboration rather than at run time
    generate
        if (NUM_CHANNELS != 8)
        begin : g_bad_channels
            $error("acrb_regs supports exactly eight channels");
        end
    endgenerate

    // register state
    logic force_all_analog_reg;
    logic offset_calibrate_reg;
    logic defaults_trigger_reg;
    logic [7:0] output_data_config_reg;
    logic [2:0] averaging_config_reg;
    logic [4:0] operating_mode_config_reg;
    logic [7:0] channel_function_map_reg;
    logic [7:0] digital_direction_map_reg;
    logic brownout_flag_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    acrb_cal_state_t cal_state_reg;
    logic [15:0] cal_count_reg;
    logic bo_sync1_reg;
    logic bo_sync2_reg;
    logic bo_seen_reg;

    // decoded bus strobes
    logic access;
    logic wr_en;
    logic rd_en;
    logic [5:0] idx;
    logic mapped;
    logic [7:0] wbyte;
    logic cal_done;
    logic bo_rise;
    logic [2:0] events;

    // byte address to register index, low bits must be zero
    function automatic logic [5:0] reg_index(input logic [31:0] addr);
        reg_index = addr[7:2];
    endfunction

    // true when the index names a register that exists
    function automatic logic is_mapped(input logic [31:0] addr);
        logic [5:0] i;
        i = reg_index(addr);
        is_mapped = (addr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) &&
                    (i == IDX_SYSTEM_STATUS || i == IDX_GENERAL_CONFIG ||
                     i == IDX_OUTPUT_DATA_CONFIG || i == IDX_AVERAGING_CONFIG ||
                     i == IDX_OPERATING_MODE_CONFIG || i == IDX_CHANNEL_FUNCTION_CONFIG ||
                     i == IDX_DIGITAL_DIRECTION_CONFIG || i == IDX_IRQ_STATUS ||
                     i == IDX_IRQ_MASK);
    endfunction

    // zero wait state slave, errors only for holes in the map
    assign access = psel && penable;
    assign idx = reg_index(paddr);
    assign mapped = is_mapped(paddr);
    assign pready = access;
    assign pslverr = access && !mapped;
    assign wr_en = access && pwrite && mapped && pstrb[0];
    assign rd_en = access && !pwrite && mapped;
    assign wbyte = pwdata[7:0];

    // read mux, reserved bits come back as zero
    always_comb
    begin
        prdata = 32'h00000000;
        unique case (idx)
            IDX_SYSTEM_STATUS:
            begin
                prdata[BIT_STATUS_ONE] = 1'b1;
                prdata[BIT_BROWNOUT] = brownout_flag_reg;
            end
            IDX_GENERAL_CONFIG:
            begin
                // the defaults trigger is write only and reads zero
                prdata[BIT_FORCE_ALL_ANALOG] = force_all_analog_reg;
                prdata[BIT_OFFSET_CALIBRATE] = offset_calibrate_reg;
            end
            IDX_OUTPUT_DATA_CONFIG: prdata[7:0] = output_data_config_reg & MASK_OUTPUT_DATA_CONFIG;
            IDX_AVERAGING_CONFIG: prdata[2:0] = averaging_config_reg;
            IDX_OPERATING_MODE_CONFIG: prdata[4:0] = operating_mode_config_reg;
            IDX_CHANNEL_FUNCTION_CONFIG: prdata[7:0] = channel_function_map_reg;
            IDX_DIGITAL_DIRECTION_CONFIG: prdata[7:0] = digital_direction_map_reg;
            IDX_IRQ_STATUS: prdata[2:0] = irq_status_reg;
            IDX_IRQ_MASK: prdata[2:0] = irq_mask_reg;
            default: prdata = 32'h00000000;
        endcase
        if (!rd_en)
        begin
            prdata = 32'h00000000;
        end
    end

    // brown-out pin through two flops, the second and a third edge-detect flop are looked at
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bo_sync1_reg <= 1'b0;
            bo_sync2_reg <= 1'b0;
            bo_seen_reg <= 1'b0;
        end
        else
        begin
            bo_sync1_reg <= brownout_det;
            bo_sync2_reg <= bo_sync1_reg;
            bo_seen_reg <= bo_sync2_reg;
        end
    end

    assign bo_rise = bo_sync2_reg && !bo_seen_reg;

    // defaults trigger lives one cycle, then the restore below takes place
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            defaults_trigger_reg <= 1'b0;
        end
        else
        begin
            defaults_trigger_reg <= wr_en && idx == IDX_GENERAL_CONFIG && wbyte[BIT_DEFAULTS_TRIGGER];
        end
    end

    // force flag; writable field only, reserved bits dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            force_all_analog_reg <= RST_CONFIG[BIT_FORCE_ALL_ANALOG];
        end
        else if (defaults_trigger_reg)
        begin
            force_all_analog_reg <= RST_CONFIG[BIT_FORCE_ALL_ANALOG];
        end
        else if (wr_en && idx == IDX_GENERAL_CONFIG)
        begin
            force_all_analog_reg <= wbyte[BIT_FORCE_ALL_ANALOG];
        end
    end

    // calibration sequencer: the bit stays up until the timer runs out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_state_reg <= CAL_IDLE;
            cal_count_reg <= 16'h0000;
            offset_calibrate_reg <= 1'b0;
        end
        else if (defaults_trigger_reg)
        begin
            cal_state_reg <= CAL_IDLE;
            cal_count_reg <= 16'h0000;
            offset_calibrate_reg <= RST_CONFIG[BIT_OFFSET_CALIBRATE];
        end
        else
        begin
            unique case (cal_state_reg)
                CAL_IDLE:
                begin
                    if (wr_en && idx == IDX_GENERAL_CONFIG && wbyte[BIT_OFFSET_CALIBRATE])
                    begin
                        cal_state_reg <= CAL_RUN;
                        cal_count_reg <= 16'(CAL_CYCLES - 1);
                        offset_calibrate_reg <= 1'b1;
                    end
                end
                CAL_RUN:
                begin
                    // a second write of one while busy is absorbed by the running cycle
                    if (cal_count_reg == 16'h0000)
                    begin
                        cal_state_reg <= CAL_IDLE;
                        offset_calibrate_reg <= 1'b0;
                    end
                    else
                    begin
                        cal_count_reg <= cal_count_reg - 16'h0001;
                    end
                end
                default:
                begin
                    cal_state_reg <= CAL_IDLE;
                    offset_calibrate_reg <= 1'b0;
                end
            endcase
        end
    end

    assign cal_done = (cal_state_reg == CAL_RUN) && (cal_count_reg == 16'h0000);
    assign cal_active = offset_calibrate_reg;

    // data formatting, averaging and oscillator fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_data_config_reg <= RST_CONFIG;
            averaging_config_reg <= RST_CONFIG[2:0];
            operating_mode_config_reg <= RST_CONFIG[4:0];
        end
        else if (defaults_trigger_reg)
        begin
            output_data_config_reg <= RST_CONFIG;
            averaging_config_reg <= RST_CONFIG[2:0];
            operating_mode_config_reg <= RST_CONFIG[4:0];
        end
        else if (wr_en)
        begin
            if (idx == IDX_OUTPUT_DATA_CONFIG)
            begin
                output_data_config_reg <= wbyte & MASK_OUTPUT_DATA_CONFIG;
            end
            if (idx == IDX_AVERAGING_CONFIG)
            begin
                averaging_config_reg <= wbyte[2:0] & MASK_AVERAGING_CONFIG[2:0];
            end
            if (idx == IDX_OPERATING_MODE_CONFIG)
            begin
                operating_mode_config_reg <= wbyte[4:0] & MASK_OPERATING_MODE_CONFIG[4:0];
            end
        end
    end

    // channel function and direction maps, full bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_function_map_reg <= RST_CONFIG;
            digital_direction_map_reg <= RST_CONFIG;
        end
        else if (defaults_trigger_reg)
        begin
            channel_function_map_reg <= RST_CONFIG;
            digital_direction_map_reg <= RST_CONFIG;
        end
        else if (wr_en)
        begin
            if (idx == IDX_CHANNEL_FUNCTION_CONFIG)
            begin
                channel_function_map_reg <= wbyte;
            end
            if (idx == IDX_DIGITAL_DIRECTION_CONFIG)
            begin
                digital_direction_map_reg <= wbyte;
            end
        end
    end

    // brownout flag: power-on reset value is one, a set beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            brownout_flag_reg <= RST_SYSTEM_STATUS[BIT_BROWNOUT];
        end
        else if (bo_rise || defaults_trigger_reg)
        begin
            brownout_flag_reg <= 1'b1;
        end
        else if (wr_en && idx == IDX_SYSTEM_STATUS && wbyte[BIT_BROWNOUT])
        begin
            brownout_flag_reg <= 1'b0;
        end
    end

    // per-channel steering, force overrides both maps
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++)
        begin : g_pin
            assign pins.is_gpio[ch] = channel_function_map_reg[ch] && !force_all_analog_reg;
            assign pins.is_output[ch] = pins.is_gpio[ch] && digital_direction_map_reg[ch];
        end
    endgenerate

    // configuration to the converter core and the spi shifter
    assign cfg.osc_low_power = operating_mode_config_reg[BIT_OSC_SELECT];
    assign cfg.timing_divider = operating_mode_config_reg[3:0];
    assign cfg.averaging_ratio = averaging_config_reg;
    assign cfg.average_count = 8'h01 << averaging_config_reg;
    assign cfg.cpol = output_data_config_reg[1];
    assign cfg.cpha = output_data_config_reg[0];
    // reserved tag codes fall back to no tag so the frame length stays known
    assign cfg.tag_enable = output_data_config_reg[5:4] == TAG_APPEND_CODE;

    // result word: code in the top twelve bits, tag in the low four or zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_word <= 16'h0000;
            data_word_valid <= 1'b0;
        end
        else
        begin
            data_word_valid <= result_valid;
            if (result_valid)
            begin
                if (output_data_config_reg[BIT_FIXED_PATTERN])
                begin
                    data_word[15:4] <= FIXED_PATTERN_CODE;
                end
                else
                begin
                    data_word[15:4] <= result_code;
                end
                data_word[3:0] <= cfg.tag_enable ? result_channel : 4'h0;
            end
        end
    end

    // interrupt events
    always_comb
    begin
        events = 3'h0;
        events[EV_CAL_DONE] = cal_done;
        events[EV_DEFAULTS_DONE] = defaults_trigger_reg;
        events[EV_BROWNOUT] = bo_rise;
    end

    // sticky status cleared by reading it; an event in that cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_reg <= RST_IRQ;
        end
        else if (rd_en && idx == IDX_IRQ_STATUS)
        begin
            irq_status_reg <= events;
        end
        else
        begin
            irq_status_reg <= irq_status_reg | events;
        end
    end

    // mask register is not touched by the defaults trigger, it is bus plumbing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_reg <= RST_IRQ;
        end
        else if (wr_en && idx == IDX_IRQ_MASK)
        begin
            irq_mask_reg <= wbyte[2:0] & MASK_IRQ;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

// >>> sim/acrb_props.sv
// checker on the adc configuration register bank ports
`timescale 1ns/100ps
module acrb_props
    import acrb_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
)
(
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // converter side
    input logic brownout_det,
    input logic result_valid,
    input logic [11:0] result_code,
    input logic [3:0] result_channel,
    input logic [15:0] data_word,
    input logic data_word_valid,
    input logic cal_active,
    input acrb_cfg_t cfg,
    input acrb_pin_t pins,
    input logic irq
);
    // calibration length, two cycles of slack each way
    localparam int CAL_LO = CAL_CYCLES - 2;
    localparam int CAL_HI = CAL_CYCLES + 2;
    logic acc;
    logic wr_ok;
    // access phase and accepted write
    assign acc = psel && penable;
    assign wr_ok = acc && pwrite && pstrb[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access phase");
    property p_unmapped;
        acc && paddr == 32'h18 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_general_rsvd;
        acc && !pwrite && paddr == 32'h04 |-> prdata[31:3] == 29'h0 && !prdata[0];
    endproperty
    a_general_rsvd: assert property (p_general_rsvd) else $error("general config bits leak");
    property p_spi_mode;
        wr_ok && paddr == 32'h08 |=> {cfg.cpol, cfg.cpha} == $past(pwdata[1:0])
            && cfg.tag_enable == ($past(pwdata[5:4]) == TAG_APPEND_CODE);
    endproperty
    a_spi_mode: assert property (p_spi_mode) else $error("spi mode or tag wrong");
    property p_opmode;
        wr_ok && paddr == 32'h10 |=> cfg.osc_low_power == $past(pwdata[4])
            && cfg.timing_divider == $past(pwdata[3:0]);
    endproperty
    a_opmode: assert property (p_opmode) else $error("operating mode fields wrong");
    property p_avg_count;
        $onehot(cfg.average_count) && cfg.average_count[cfg.averaging_ratio];
    endproperty
    a_avg_count: assert property (p_avg_count) else $error("sample count wrong");
    property p_dvalid;
        1'b1 |=> data_word_valid == $past(result_valid);
    endproperty
    a_dvalid: assert property (p_dvalid) else $error("data word valid misplaced");
    property p_tag;
        data_word_valid |-> data_word[3:0] == ($past(cfg.tag_enable) ? $past(result_channel) : 4'h0);
    endproperty
    a_tag: assert property (p_tag) else $error("channel tag wrong");
    property p_cal_hold;
        $rose(cal_active) |-> cal_active [*8];
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("calibration ended early");
    property p_cal_end;
        $rose(cal_active) |-> ##[CAL_LO:CAL_HI] !cal_active;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration did not end");
endmodule
bind acrb_regs acrb_props #(.NUM_CHANNELS(NUM_CHANNELS)) chk_u (.*);

// >>> sim/acrb_core_model.sv
// converter core stand-in feeding results and brown-out events
`timescale 1ns/100ps
module acrb_core_model
(
    // clock
    input logic pclk,
    // results and brown-out
    output logic result_valid,
    output logic [11:0] result_code,
    output logic [3:0] result_channel,
    output logic brownout_det
);
    // idle values at time zero
    initial
    begin
        result_valid = 1'b0;
        result_code = 12'h000;
        result_channel = 4'h0;
        brownout_det = 1'b0;
    end
    // one result pulse; fields scrambled after so stale values never match
    task automatic send(input logic [11:0] code, input logic [3:0] ch);
        @(posedge pclk);
        result_valid <= 1'b1;
        result_code <= code;
        result_channel <= ch;
        @(posedge pclk);
        result_valid <= 1'b0;
        result_code <= ~code;
        result_channel <= ~ch;
    endtask
    // pulse long enough to cross the two-flop synchroniser
    task automatic brown();
        @(posedge pclk);
        brownout_det <= 1'b1;
        repeat (4) @(posedge pclk);
        brownout_det <= 1'b0;
    endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the adc configuration register bank
`timescale 1ns/100ps
module tb_top;
    import acrb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb, result_channel;
    logic result_valid, brownout_det, data_word_valid, cal_active;
    logic [11:0] result_code;
    logic [15:0] data_word;
    acrb_cfg_t cfg;
    acrb_pin_t pins;
    int mismatches;
    int checks;
    localparam logic [31:0] CFG_A [6] = '{32'h04, 32'h08, 32'h0C, 32'h10, 32'h14, 32'h1C};
    localparam logic [7:0] CFG_W [6] = '{8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] CFG_X [6] = '{8'h04, 8'hB3, 8'h07, 8'h1F, 8'hFF, 8'hFF};
    acrb_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .brownout_det, .result_valid, .result_code, .result_channel, .data_word,
        .data_word_valid, .cal_active, .cfg, .pins, .irq);
    acrb_core_model core_u (.pclk, .result_valid, .result_code, .result_channel, .brownout_det);
    // 125 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
            $display("MISMATCH time=%0t seen=%h expected=%h", $time, got, exp);
        if (got !== exp)
            mismatches++;
    endtask
    // one apb transfer, held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, {24'h0, x});
    endtask
    // result through the core model, word seen one cycle later
    task automatic res(input logic [11:0] c, input logic [3:0] ch, input logic [15:0] x);
        core_u.send(c, ch);
        #1;
        chk({31'h0, data_word_valid}, 32'h1);
        chk({16'h0, data_word}, {16'h0, x});
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far beyond the expected run length
    initial
    begin
        #(8 * 20000);
        mismatches++;
        test_done();
    end
    // main sequence
    initial
    begin
        int i;
        logic [31:0] r;
        logic e;
        {psel, penable, pwrite, paddr, pwdata, presetn, mismatches, checks} = '0;
        pstrb = 4'hF;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(32'h00, 8'h81);
        for (i = 0; i < 6; i++)
            rd(CFG_A[i], 8'h00);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 32'h18, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        wr(32'h00, 8'h01);
        rd(32'h00, 8'h80);
        // all ones into every config register but general config, which gets 0xFC; reserved bits must stay clear
        for (i = 0; i < 6; i++)
        begin
            wr(CFG_A[i], CFG_W[i]);
            rd(CFG_A[i], CFG_X[i]);
        end
        chk({24'h0, pins.is_gpio}, 32'h0);
        wr(32'h04, 8'h00);
        chk({16'h0, pins}, 32'hFFFF);
        wr(32'h14, 8'h0F);
        wr(32'h1C, 8'h05);
        chk({16'h0, pins}, 32'h0F05);
        wr(32'h10, 8'h1A);
        chk({27'h0, cfg.osc_low_power, cfg.timing_divider}, 32'h1A);
        wr(32'h10, 8'h05);
        chk({27'h0, cfg.osc_low_power, cfg.timing_divider}, 32'h05);
        for (i = 0; i < 8; i++)
        begin
            wr(32'h0C, i[7:0]);
            chk({21'h0, cfg.averaging_ratio, cfg.average_count}, {21'h0, i[2:0], 8'h01 << i});
        end
        for (i = 0; i < 4; i++)
        begin
            wr(32'h08, i[7:0]);
            chk({30'h0, cfg.cpol, cfg.cpha}, i);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(32'h08, {2'b00, i[1:0], 4'h0});
            res(12'h120 | i[11:0], 4'h3 + i[3:0], {12'h120 | i[11:0], i == 1 ? 4'h3 + i[3:0] : 4'h0});
        end
        wr(32'h08, 8'h91);
        res(12'h3C3, 4'h6, {12'hA5A, 4'h6});
        // calibration done raises irq with all three events unmasked
        wr(32'h84, 8'h07);
        wr(32'h04, 8'h02);
        rd(32'h04, 8'h02);
        r = 32'h2;
        for (i = 0; i < 40 && r[1]; i++)
            apb(1'b0, 32'h04, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(32'h80, 8'h01);
        chk({31'h0, irq}, 32'h0);
        // masked brown-out keeps the line low
        wr(32'h84, 8'h00);
        core_u.brown();
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(32'h80, 8'h04);
        rd(32'h00, 8'h81);
        wr(32'h00, 8'h01);
        wr(32'h08, 8'hB3);
        wr(32'h04, 8'h05);
        chk({16'h0, pins}, 32'h0);
        rd(32'h0C, 8'h00);
        rd(32'h14, 8'h00);
        rd(32'h08, 8'h00);
        rd(32'h04, 8'h00);
        rd(32'h00, 8'h81);
        rd(32'h80, 8'h02);
        test_done();
    end
endmodule
